// file: logic/sub_alu.sv
// combinational subtractor: a minus b with status flags
`timescale 1ns/1ns
`default_nettype none
module sub_alu #(
  parameter int W = 8
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output logic [W-1:0] diff,
  output logic [4:0] flags
);
  logic [W:0] full;
  logic [sub_pkg::NIBBLE_W:0] half;
  always_comb begin
    full = {1'b0, a} + {1'b0, ~b} + {{W{1'b0}}, 1'b1};
    half = {1'b0, a[sub_pkg::NIBBLE_W-1:0]} + {1'b0, ~b[sub_pkg::NIBBLE_W-1:0]} + {{sub_pkg::NIBBLE_W{1'b0}}, 1'b1};
    diff = full[W-1:0];
    flags[sub_pkg::FLAG_C] = full[W];
    flags[sub_pkg::FLAG_DC] = half[sub_pkg::NIBBLE_W];
    flags[sub_pkg::FLAG_Z] = (full[W-1:0] == '0);
    flags[sub_pkg::FLAG_N] = full[W-1];
    flags[sub_pkg::FLAG_OV] = (a[W-1] != b[W-1]) && (full[W-1] != a[W-1]);
  end
endmodule : sub_alu
`default_nettype wire

// file: logic/sub_datapath.sv
// subtract instruction datapath: literal minus acc and file minus acc
// Behaviour
// - literal opcode: literal minus accumulator, difference written to accumulator
// - file opcode: file register minus accumulator, updating N OV C DC Z
// - destination bit zero writes accumulator, one writes file register back
// - bank bit one uses bank pointer, zero uses fixed access bank
`timescale 1ns/1ns
`default_nettype none
module sub_datapath #(
  parameter int W = 8
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR,
  input wire logic [3:0] BANK_SELECT_POINTER,
  input wire logic [W-1:0] FILE_RDATA,
  output logic [sub_pkg::FADDR_W-1:0] FILE_ADDR,
  output logic FILE_RD,
  output logic FILE_WE,
  output logic [W-1:0] FILE_WDATA,
  output logic [W-1:0] ACC,
  output logic [4:0] FLAGS,
  output logic DONE,
  output logic BUSY
);
  localparam int OPC_HI_IDX = sub_pkg::OPC_HI;
  localparam int LIT_OPC_W = $bits(sub_pkg::LIT_SUB_OPC);
  localparam int FILE_OPC_W = $bits(sub_pkg::FILE_SUB_OPC);
  localparam int F_W = sub_pkg::FIELD_W;

  // ----------------------------------------------------------------
  // types and state
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    IDLE = 5'h01, DECODE = 5'h02, READ = 5'h04, PROC = 5'h08, WRITE = 5'h10
  } phase_t;
  typedef enum logic [1:0] {
    OP_NONE = 2'h0, OP_LIT = 2'h1, OP_FILE = 2'h2
  } op_t;

  phase_t ph_q, ph_d;
  op_t op_q, op_d;
  logic [15:0] ir_q, ir_d;
  logic [W-1:0] opnd_q, opnd_d;
  logic [W-1:0] res_q, res_d;
  logic [W-1:0] acc_q, acc_d;
  logic [W-1:0] wdata_q, wdata_d;
  logic [4:0] flg_q, flg_d;
  logic [4:0] alu_flags;
  logic [W-1:0] alu_diff;
  logic [sub_pkg::FADDR_W-1:0] addr_q, addr_d;
  logic rd_q, rd_d;
  logic we_q, we_d;
  logic done_q, done_d;
  logic busy_q, busy_d;
  logic is_lit;
  logic is_file;
  logic [sub_pkg::FADDR_W-1:0] opnd_addr;

  sub_alu #(.W(W)) u_alu (
    .a(opnd_q),
    .b(acc_q),
    .diff(alu_diff),
    .flags(alu_flags)
  );

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  // the two opcode patterns never overlap, so at most one of these is set
  always_comb begin
    is_lit = (ir_q[OPC_HI_IDX -: LIT_OPC_W] == sub_pkg::LIT_SUB_OPC);
    is_file = (ir_q[OPC_HI_IDX -: FILE_OPC_W] == sub_pkg::FILE_SUB_OPC);
    if (ir_q[sub_pkg::BANK_BIT]) begin
      opnd_addr = {BANK_SELECT_POINTER, ir_q[F_W-1:0]};
    end else begin
      opnd_addr = {sub_pkg::ACCESS_BANK, ir_q[F_W-1:0]};
    end
  end

  // ----------------------------------------------------------------
  // phase machine
  // ----------------------------------------------------------------
  always_comb begin
    ph_d = ph_q;
    op_d = op_q;
    ir_d = ir_q;
    busy_d = 1'b1;
    done_d = 1'b0;
    unique case (ph_q)
      IDLE: begin
        busy_d = 1'b0;
        if (INSTR_VALID) begin
          ir_d = INSTR;
          busy_d = 1'b1;
          ph_d = DECODE;
        end
      end
      DECODE: begin
        if (is_lit) begin
          op_d = OP_LIT;
        end else if (is_file) begin
          op_d = OP_FILE;
        end else begin
          op_d = OP_NONE;
        end
        ph_d = READ;
      end
      READ: begin
        ph_d = PROC;
      end
      PROC: begin
        ph_d = WRITE;
      end
      WRITE: begin
        // back to idle in the done cycle so the next word can be taken there
        done_d = 1'b1;
        busy_d = 1'b0;
        ph_d = IDLE;
      end
      default: begin
        busy_d = 1'b0;
        ph_d = IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ph_q <= IDLE;
      op_q <= OP_NONE;
      ir_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      ph_q <= ph_d;
      op_q <= op_d;
      ir_q <= ir_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  // ----------------------------------------------------------------
  // operand and result
  // ----------------------------------------------------------------
  always_comb begin
    opnd_d = opnd_q;
    res_d = res_q;
    if (ph_q == DECODE && is_lit) begin
      opnd_d = W'(ir_q[F_W-1:0]);
    end
    if (ph_q == READ && op_q == OP_FILE) begin
      opnd_d = FILE_RDATA;
    end
    if (ph_q == PROC) begin
      res_d = alu_diff;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      opnd_q <= '0;
      res_q <= '0;
    end else begin
      opnd_q <= opnd_d;
      res_q <= res_d;
    end
  end

  // ----------------------------------------------------------------
  // accumulator and status flags
  // ----------------------------------------------------------------
  // alu inputs are unchanged since the process phase, so its flags still match res_q
  always_comb begin
    acc_d = acc_q;
    flg_d = flg_q;
    if (ph_q == WRITE && op_q != OP_NONE) begin
      flg_d = alu_flags;
      if (op_q == OP_LIT || !ir_q[sub_pkg::DEST_BIT]) begin
        acc_d = res_q;
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      acc_q <= sub_pkg::ACC_RESET;
      flg_q <= sub_pkg::FLAGS_RESET;
    end else begin
      acc_q <= acc_d;
      flg_q <= flg_d;
    end
  end

  // ----------------------------------------------------------------
  // file register port
  // ----------------------------------------------------------------
  always_comb begin
    addr_d = addr_q;
    wdata_d = wdata_q;
    rd_d = 1'b0;
    we_d = 1'b0;
    if (ph_q == DECODE && is_file) begin
      addr_d = opnd_addr;
      rd_d = 1'b1;
    end
    if (ph_q == WRITE && op_q == OP_FILE && ir_q[sub_pkg::DEST_BIT]) begin
      we_d = 1'b1;
      wdata_d = res_q;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      addr_q <= '0;
      wdata_q <= '0;
      rd_q <= 1'b0;
      we_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rd_q <= rd_d;
      we_q <= we_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign FILE_ADDR = addr_q;
  assign FILE_RD = rd_q;
  assign FILE_WE = we_q;
  assign FILE_WDATA = wdata_q;
  assign ACC = acc_q;
  assign FLAGS = flg_q;
  assign DONE = done_q;
  assign BUSY = busy_q;
endmodule : sub_datapath
`default_nettype wire

// file: logic/sub_pkg.sv
// shared constants for the subtract datapath
package sub_pkg;
  localparam logic [7:0] LIT_SUB_OPC = 8'h08;
  localparam logic [5:0] FILE_SUB_OPC = 6'h17;
  localparam int OPC_HI = 15;
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  localparam int FADDR_W = 12;
  localparam int FIELD_W = 8;
  localparam int NIBBLE_W = 4;
  localparam logic [3:0] ACCESS_BANK = 4'h0;
  localparam int FLAG_N = 4;
  localparam int FLAG_OV = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_DC = 1;
  localparam int FLAG_C = 0;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
endpackage : sub_pkg

// file: sim/file_mem_model.sv
// file register model
`timescale 1ns/1ns
`default_nettype none
module file_mem_model (
  input wire logic CLK,
  input wire logic [11:0] FILE_ADDR,
  input wire logic FILE_RD,
  input wire logic FILE_WE,
  input wire logic [7:0] FILE_WDATA,
  output logic [7:0] FILE_RDATA
);
  logic [7:0] mem [4096];
  always @(posedge CLK) begin
    if (FILE_WE) mem[FILE_ADDR] <= FILE_WDATA;
  end
  // outside a read the bus shows the inverse
  assign FILE_RDATA = FILE_RD ? mem[FILE_ADDR] : ~mem[FILE_ADDR];
endmodule : file_mem_model
`default_nettype wire

// file: sim/sub_datapath_props.sv
// port checker
`timescale 1ns/1ns
`default_nettype none
module sub_datapath_props (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR,
  input wire logic FILE_RD,
  input wire logic FILE_WE,
  input wire logic [7:0] ACC,
  input wire logic [4:0] FLAGS,
  input wire logic DONE,
  input wire logic BUSY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  wire logic t = INSTR_VALID && !BUSY;
  wire logic f = t && (INSTR[sub_pkg::OPC_HI -: $bits(sub_pkg::FILE_SUB_OPC)] == sub_pkg::FILE_SUB_OPC);
  wire logic l = t && (INSTR[sub_pkg::OPC_HI -: $bits(sub_pkg::LIT_SUB_OPC)] == sub_pkg::LIT_SUB_OPC);
  wire logic d = INSTR[sub_pkg::DEST_BIT];
  chk_done_time: assert property (t |=> BUSY[*4] ##1 DONE) else $error("timing");
  chk_file_read: assert property (f |-> ##2 FILE_RD) else $error("read");
  chk_file_dest: assert property (f && d |-> ##5 FILE_WE && ACC == $past(ACC)) else $error("dest");
  chk_acc_dest: assert property (t && !(f && d) |-> ##5 !FILE_WE) else $error("write");
  chk_lit_diff: assert property (l |-> ##5 ACC == 8'($past(INSTR, 5)) - $past(ACC))
    else $error("diff");
  chk_lit_carry: assert property (l |-> ##5 FLAGS[sub_pkg::FLAG_C] == (8'($past(INSTR, 5)) >= $past(ACC)))
    else $error("carry");
  chk_zero_flag: assert property (DONE && $changed(ACC) |-> FLAGS[sub_pkg::FLAG_Z] == (ACC == 8'h00))
    else $error("zero");
  cover property (f);
  cover property (f && d);
  cover property (DONE && !FLAGS[sub_pkg::FLAG_C]);
  cover property (DONE && FLAGS[sub_pkg::FLAG_OV]);
endmodule : sub_datapath_props
bind sub_datapath sub_datapath_props u_props (
  .CLK(CLK),
  .RSTN(RSTN),
  .INSTR_VALID(INSTR_VALID),
  .INSTR(INSTR),
  .FILE_RD(FILE_RD),
  .FILE_WE(FILE_WE),
  .ACC(ACC),
  .FLAGS(FLAGS),
  .DONE(DONE),
  .BUSY(BUSY)
);
`default_nettype wire

// file: sim/test_sub_datapath.sv
// subtract datapath bench
`timescale 1ns/1ns
`default_nettype none
module test_sub_datapath;
  logic CLK = 1'h0, RSTN = 1'h0, INSTR_VALID = 1'h0, FILE_RD, FILE_WE, DONE, BUSY;
  logic [15:0] INSTR = 16'h0000;
  logic [3:0] BANK_SELECT_POINTER = 4'h5;
  logic [7:0] FILE_RDATA, FILE_WDATA, ACC;
  logic [11:0] FILE_ADDR;
  logic [4:0] FLAGS;
  int failures = 0, n_tests = 0;
  always #10 CLK = ~CLK;
  sub_datapath DUT (
    .CLK(CLK), .RSTN(RSTN), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
    .BANK_SELECT_POINTER(BANK_SELECT_POINTER), .FILE_RDATA(FILE_RDATA), .FILE_ADDR(FILE_ADDR),
    .FILE_RD(FILE_RD), .FILE_WE(FILE_WE), .FILE_WDATA(FILE_WDATA), .ACC(ACC), .FLAGS(FLAGS),
    .DONE(DONE), .BUSY(BUSY)
  );
  file_mem_model mdl (
    .CLK(CLK), .FILE_ADDR(FILE_ADDR), .FILE_RD(FILE_RD), .FILE_WE(FILE_WE),
    .FILE_WDATA(FILE_WDATA), .FILE_RDATA(FILE_RDATA)
  );
  task automatic check(input logic [23:0] s, e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %0t saw %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic end_of_test;
    $display("%0d checks %0d failures", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  task automatic run(input logic [15:0] i, r);
    int n;
    @(posedge CLK);
    INSTR_VALID <= 1'h1;
    INSTR <= i;
    @(posedge CLK);
    INSTR_VALID <= 1'h0;
    @(negedge CLK);
    for (n = 0; n < 9 && DONE !== 1'h1; n++) @(negedge CLK);
    if (n == 9) begin failures++; end_of_test(); end
    check({8'h00, ACC, 3'h0, FLAGS}, {8'h00, r});
  endtask : run
  task automatic lit_chain;
    run(16'h0802, 16'h0203);
    run(16'h0802, 16'h0007);
    run(16'h08FF, 16'hFF13);
  endtask : lit_chain
  task automatic file_to_acc;
    mdl.mem[12'h010] = 8'h80;
    run(16'h5C10, 16'h8110);
  endtask : file_to_acc
  task automatic file_to_reg;
    mdl.mem[12'h520] = 8'h05;
    run(16'h5F20, 16'h811A);
    check({3'h0, FILE_WE, FILE_ADDR, FILE_WDATA}, 24'h152084);
    run(16'hFFFF, 16'h811A);
    check({16'h0000, mdl.mem[12'h520]}, 24'h000084);
  endtask : file_to_reg
  initial begin
    repeat (12) @(posedge CLK);
    RSTN <= 1'h1;
    lit_chain();
    file_to_acc();
    file_to_reg();
    end_of_test();
  end
endmodule : test_sub_datapath
`default_nettype wire
